// >>> hw/pstp_consts.svh
// What this block does
// - count errored self-test nibbles in an 8-bit counter, register bits 15:8
// - clear the error counter whenever a packet self test restarts
// - error counter saturates at its maximum until the test restarts
// - continuous mode sends pseudo-random data with no gaps between packets
// - continuous mode acts only together with the separate start controls
// - pattern enable bit turns 10 Mb/s test pattern on or off, resets zero
// - gap select bit picks 15 us idle when one, 10 us when zero
// - two-bit select picks data form0, data form1, link pulses or Manchester ones
// - jabber-disable bit turns the 10BASE-T jabber function off
`ifndef PSTP_CONSTS_SVH
`define PSTP_CONSTS_SVH
`define PSTP_ADDR_TENBASE_SC 5'h1A
`define PSTP_ADDR_CTRL 5'h1B
`define PSTP_ADDR_IRQ_STATUS 5'h1C
`define PSTP_ADDR_IRQ_CLEAR 5'h1D
`define PSTP_ADDR_IRQ_ENABLE 5'h1E
`define PSTP_ERRCNT_HI 15
`define PSTP_ERRCNT_LO 8
`define PSTP_CONT_BIT 5
`define PSTP_PATT_EN_BIT 4
`define PSTP_GAP_BIT 2
`define PSTP_JABBER_DIS_BIT 0
`define PSTP_ERRCNT_MAX 8'hFF
`define PSTP_CLK_MHZ 100
`define PSTP_GAP_LONG_US 15
`define PSTP_GAP_SHORT_US 10
`define PSTP_GAP_LONG_CYC (`PSTP_GAP_LONG_US * `PSTP_CLK_MHZ)
`define PSTP_GAP_SHORT_CYC (`PSTP_GAP_SHORT_US * `PSTP_CLK_MHZ)
`define PSTP_IRQ_SAT_BIT 0
`define PSTP_IRQ_ERR_BIT 1
`define PSTP_IRQ_GAP_BIT 2
`endif

// >>> hw/pstp_pkg.sv
package pstp_pkg;
    typedef enum logic [1:0] {
        PSTP_PAT_DATA_END_OF_PACKET_FORM0,
        PSTP_PAT_DATA_END_OF_PACKET_FORM1,
        PSTP_PAT_LINK_PULSE,
        PSTP_PAT_MANCH_ONES
    } pstp_pattern_t;
    typedef enum logic [1:0] {
        PSTP_SEQ_IDLE,
        PSTP_SEQ_SEND,
        PSTP_SEQ_GAP
    } pstp_seq_state_t;
endpackage

// >>> hw/pstp_gap_timer.sv
`timescale 1ns/1ps
`include "pstp_consts.svh"
// counts down the idle interval between test sequences
module pstp_gap_timer (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic long_gap_in,
    output logic done_out
);
    logic [10:0] count;
    logic running;

    // load on start, pulse done when the count reaches one
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            count <= 11'h000;
            running <= 1'b0;
            done_out <= 1'b0;
        end else if (start_in) begin
            count <= long_gap_in ? 11'(`PSTP_GAP_LONG_CYC) : 11'(`PSTP_GAP_SHORT_CYC);
            running <= 1'b1;
            done_out <= 1'b0;
        end else if (running) begin
            done_out <= (count == 11'h001);
            running <= (count != 11'h001);
            count <= count - 11'h001;
        end else begin
            done_out <= 1'b0;
        end
    end
endmodule

// >>> hw/pstp_ctrl.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "pstp_consts.svh"
// self-test error counter, continuous mode gating and 10 Mb/s pattern control
module pstp_ctrl (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic selftest_start_in,
    input wire logic selftest_active_in,
    input wire logic nibble_error_in,
    input wire logic seq_done_in,
    output logic continuous_tx_out,
    output logic pattern_active_out,
    output logic [1:0] pattern_select_out,
    output logic seq_start_out,
    output logic jabber_enable_out,
    output logic irq_out
);
    logic [7:0] err_count;
    logic continuous_selftest_tx;
    logic tenmeg_pattern_enable;
    logic pattern_gap_select;
    logic [1:0] pattern_select;
    logic jabber_disable;
    logic [2:0] irq_status;
    logic [2:0] irq_enable;
    logic [2:0] irq_event;
    logic gap_done;
    pstp_pkg::pstp_seq_state_t seq_state;
    pstp_pkg::pstp_seq_state_t next_seq_state;

    // write decode shared by every register
    function automatic logic wr_hit(input logic [4:0] addr, input logic [4:0] target, input logic wr);
        return wr && (addr == target);
    endfunction

    // control fields of the self-test register; reserved bits are not stored
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            continuous_selftest_tx <= 1'b0;
            tenmeg_pattern_enable <= 1'b0;
            pattern_gap_select <= 1'b0;
            pattern_select <= 2'h0;
        end else if (wr_hit(reg_addr_in, `PSTP_ADDR_CTRL, reg_wr_in)) begin
            continuous_selftest_tx <= reg_wdata_in[`PSTP_CONT_BIT];
            tenmeg_pattern_enable <= reg_wdata_in[`PSTP_PATT_EN_BIT];
            pattern_gap_select <= reg_wdata_in[`PSTP_GAP_BIT];
            pattern_select <= reg_wdata_in[1:0];
        end
    end

    // jabber disable bit of the 10BASE-T status/control register
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            jabber_disable <= 1'b0;
        end else if (wr_hit(reg_addr_in, `PSTP_ADDR_TENBASE_SC, reg_wr_in)) begin
            jabber_disable <= reg_wdata_in[`PSTP_JABBER_DIS_BIT];
        end
    end
    assign jabber_enable_out = ~jabber_disable;

    // errored nibble counter: restart clears, saturates at max
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            err_count <= 8'h00;
        end else if (selftest_start_in) begin
            err_count <= 8'h00;
        end else if (selftest_active_in && nibble_error_in && err_count != `PSTP_ERRCNT_MAX) begin
            err_count <= err_count + 8'h01;
        end
    end

    // continuous transmit only while the self test has been started
    assign continuous_tx_out = continuous_selftest_tx && selftest_active_in;
    assign pattern_active_out = tenmeg_pattern_enable;
    assign pattern_select_out = pattern_select;

    // sequence/gap state machine for the 10 Mb/s patterns
    always_comb begin
        next_seq_state = seq_state;
        case (seq_state)
            pstp_pkg::PSTP_SEQ_IDLE: begin
                if (tenmeg_pattern_enable) begin
                    next_seq_state = pstp_pkg::PSTP_SEQ_SEND;
                end
            end
            pstp_pkg::PSTP_SEQ_SEND: begin
                if (!tenmeg_pattern_enable) begin
                    next_seq_state = pstp_pkg::PSTP_SEQ_IDLE;
                end else if (seq_done_in && pattern_select != 2'(pstp_pkg::PSTP_PAT_MANCH_ONES)) begin
                    next_seq_state = pstp_pkg::PSTP_SEQ_GAP;
                end
            end
            pstp_pkg::PSTP_SEQ_GAP: begin
                if (!tenmeg_pattern_enable) begin
                    next_seq_state = pstp_pkg::PSTP_SEQ_IDLE;
                end else if (gap_done) begin
                    next_seq_state = pstp_pkg::PSTP_SEQ_SEND;
                end
            end
            default: begin
                next_seq_state = pstp_pkg::PSTP_SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            seq_state <= pstp_pkg::PSTP_SEQ_IDLE;
        end else begin
            seq_state <= next_seq_state;
        end
    end

    // start pulse for each sequence
    assign seq_start_out = (seq_state != pstp_pkg::PSTP_SEQ_SEND) && (next_seq_state == pstp_pkg::PSTP_SEQ_SEND);

    pstp_gap_timer u_gap (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .start_in((seq_state == pstp_pkg::PSTP_SEQ_SEND) && (next_seq_state == pstp_pkg::PSTP_SEQ_GAP)),
        .long_gap_in(pattern_gap_select),
        .done_out(gap_done)
    );

    // interrupt events: saturation reached, any nibble error while the self test is active, gap ended
    always_comb begin
        irq_event = 3'h0;
        irq_event[`PSTP_IRQ_SAT_BIT] = selftest_active_in && nibble_error_in && err_count == 8'hFE;
        irq_event[`PSTP_IRQ_ERR_BIT] = selftest_active_in && nibble_error_in;
        // a timer left running after the pattern was disabled must not raise a gap event
        irq_event[`PSTP_IRQ_GAP_BIT] = gap_done && (seq_state == pstp_pkg::PSTP_SEQ_GAP);
    end

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            irq_status <= 3'h0;
        end else if (wr_hit(reg_addr_in, `PSTP_ADDR_IRQ_CLEAR, reg_wr_in)) begin
            irq_status <= (irq_status & ~reg_wdata_in[2:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            irq_enable <= 3'h0;
        end else if (wr_hit(reg_addr_in, `PSTP_ADDR_IRQ_ENABLE, reg_wr_in)) begin
            irq_enable <= reg_wdata_in[2:0];
        end
    end
    assign irq_out = |(irq_status & irq_enable);

    // read data one cycle after the strobe; reserved bits read zero
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `PSTP_ADDR_CTRL: reg_rdata_out <= {err_count, 2'h0, continuous_selftest_tx,
                    tenmeg_pattern_enable, 1'b0, pattern_gap_select, pattern_select};
                `PSTP_ADDR_TENBASE_SC: reg_rdata_out <= {15'h0000, jabber_disable};
                `PSTP_ADDR_IRQ_STATUS: reg_rdata_out <= {13'h0000, irq_status};
                `PSTP_ADDR_IRQ_ENABLE: reg_rdata_out <= {13'h0000, irq_enable};
                default: reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    // checks
    a_err_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
        selftest_start_in |=> err_count == 8'h00) else $error("error counter not cleared");
    a_err_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!selftest_start_in && selftest_active_in && nibble_error_in && err_count != 8'hFF)
        |=> err_count == $past(err_count) + 8'h01) else $error("error counter missed a nibble");
    a_err_saturate: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (err_count == 8'hFF && !selftest_start_in) |=> err_count == 8'hFF) else $error("counter wrapped");
    a_cont_gated: assert property (@(posedge core_clk_in) disable iff (rst_in)
        continuous_tx_out |-> selftest_active_in) else $error("continuous without start");
    a_cont_follow: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (continuous_selftest_tx && selftest_active_in) |-> continuous_tx_out) else $error("continuous dropped");
    a_patt_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !tenmeg_pattern_enable |=> seq_state == pstp_pkg::PSTP_SEQ_IDLE) else $error("pattern runs disabled");
    a_gap_short: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (u_gap.start_in && !u_gap.long_gap_in) |=> u_gap.count == 11'd1000) else $error("short gap wrong");
    a_gap_long: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (u_gap.start_in && u_gap.long_gap_in) |=> u_gap.count == 11'd1500) else $error("long gap wrong");
    a_jabber_bit: assert property (@(posedge core_clk_in) disable iff (rst_in)
        wr_hit(reg_addr_in, `PSTP_ADDR_TENBASE_SC, reg_wr_in) |=> jabber_enable_out == !$past(reg_wdata_in[0]))
        else $error("jabber control wrong");
    a_sel_pass: assert property (@(posedge core_clk_in) disable iff (rst_in)
        wr_hit(reg_addr_in, `PSTP_ADDR_CTRL, reg_wr_in) |=> pattern_select_out == $past(reg_wdata_in[1:0]))
        else $error("pattern select wrong");
    c_saturate: cover property (@(posedge core_clk_in) err_count == 8'hFF);
    c_gap_done: cover property (@(posedge core_clk_in) gap_done);
    c_cont_tx: cover property (@(posedge core_clk_in) continuous_tx_out);
endmodule

// >>> test/pstp_partner.sv
`timescale 1ns/1ps
// line-side test equipment: echoes sequences and flags errored nibbles
module pstp_partner #(parameter int SEND_LEN = 20) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic seq_start_in,
    input wire logic err_cmd_in,
    output logic seq_done_out,
    output logic nibble_error_out
);
    int cnt;
    // one sequence lasts SEND_LEN cycles, then a one-cycle done pulse
    always_ff @(posedge core_clk_in) begin
        seq_done_out <= 1'b0;
        if (rst_in) begin
            cnt <= 0;
        end else if (seq_start_in) begin
            cnt <= SEND_LEN;
        end else if (cnt == 1) begin
            cnt <= 0;
            seq_done_out <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
    // errored nibble reported one cycle after the bench asks
    always_ff @(posedge core_clk_in) begin
        nibble_error_out <= rst_in ? 1'b0 : err_cmd_in;
    end
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
`include "pstp_consts.svh"
module testbench;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [4:0] reg_addr_in = 5'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic selftest_start_in = 1'b0;
    logic selftest_active_in = 1'b0;
    logic err_cmd = 1'b0;
    logic [15:0] reg_rdata_out;
    logic [1:0] pattern_select_out;
    logic continuous_tx_out, pattern_active_out, seq_start_out, jabber_enable_out, irq_out, seq_done_in, nibble_error_in;
    logic [31:0] seed = 32'h3F1B2AEC;
    logic [15:0] ctrl;
    int miscompares = 0;
    int n_checks = 0;
    int errcnt = 0;
    int n;
    always #5 core_clk_in = ~core_clk_in;
    pstp_ctrl pstp_ctrl_i (.core_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .selftest_start_in, .selftest_active_in, .nibble_error_in, .seq_done_in,
        .continuous_tx_out, .pattern_active_out, .pattern_select_out, .seq_start_out, .jabber_enable_out, .irq_out);
    pstp_partner pstp_partner_i (.core_clk_in, .rst_in, .seq_start_in(seq_start_out), .err_cmd_in(err_cmd),
        .seq_done_out(seq_done_in), .nibble_error_out(nibble_error_in));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // compare one value seen at the ports with the model
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        @(posedge core_clk_in);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(what, exp, reg_rdata_out);
    endtask
    // back-to-back errored nibbles; model counts only while active, saturating
    task automatic errs(input int k);
        @(posedge core_clk_in);
        err_cmd <= 1'b1;
        repeat (k) @(posedge core_clk_in);
        err_cmd <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        if (selftest_active_in) errcnt = (errcnt + k > 255) ? 255 : errcnt + k;
    endtask
    // bounded wait for a done pulse (sel 1) or a start pulse (sel 0)
    task automatic wait_for(input bit sel, input int lim);
        n = 0;
        do begin
            @(posedge core_clk_in);
            #1 n++;
        end while (((sel ? seq_done_in : seq_start_out) !== 1'b1) && n < lim);
        if ((sel ? seq_done_in : seq_start_out) !== 1'b1) begin
            miscompares++;
            $display("Error wait expected pulse seen none");
            end_of_test();
        end
    endtask
    initial begin
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rd(`PSTP_ADDR_CTRL, 16'h0000, "ctrl reset");
        chk("jabber_en", 16'h0001, {15'h0000, jabber_enable_out});
        // every pattern code, random enable and gap, reserved bits kept zero
        for (int s = 0; s < 4; s++) begin
            seed = lfsr(seed);
            ctrl = {seed[15:8], 3'b000, seed[4], 1'b0, seed[2], s[1:0]};
            wr(`PSTP_ADDR_CTRL, ctrl);
            rd(`PSTP_ADDR_CTRL, {8'h00, ctrl[7:0]}, "ctrl");
            chk("sel", {14'h0000, ctrl[1:0]}, {14'h0000, pattern_select_out});
            chk("en", {15'h0000, ctrl[4]}, {15'h0000, pattern_active_out});
        end
        rd(5'h05, 16'h0000, "unmapped");
        wr(`PSTP_ADDR_TENBASE_SC, 16'h0001);
        chk("jabber_en", 16'h0000, {15'h0000, jabber_enable_out});
        wr(`PSTP_ADDR_CTRL, 16'h0020);
        chk("cont idle", 16'h0000, {15'h0000, continuous_tx_out});
        selftest_active_in <= 1'b1;
        @(posedge core_clk_in);
        #1 chk("cont run", 16'h0001, {15'h0000, continuous_tx_out});
        wr(`PSTP_ADDR_IRQ_CLEAR, 16'h0007);
        wr(`PSTP_ADDR_IRQ_ENABLE, 16'h0001);
        @(posedge core_clk_in);
        selftest_start_in <= 1'b1;
        @(posedge core_clk_in);
        selftest_start_in <= 1'b0;
        errcnt = 0;
        errs(5);
        rd(`PSTP_ADDR_CTRL, {errcnt[7:0], 8'h20}, "errcnt");
        selftest_active_in <= 1'b0;
        errs(3);
        rd(`PSTP_ADDR_CTRL, {errcnt[7:0], 8'h20}, "errcnt idle");
        selftest_active_in <= 1'b1;
        errs(300);
        rd(`PSTP_ADDR_CTRL, {errcnt[7:0], 8'h20}, "errcnt sat");
        chk("irq", 16'h0001, {15'h0000, irq_out});
        rd(`PSTP_ADDR_IRQ_STATUS, 16'h0003, "irq status");
        wr(`PSTP_ADDR_IRQ_ENABLE, 16'h0000);
        chk("irq masked", 16'h0000, {15'h0000, irq_out});
        @(posedge core_clk_in);
        selftest_start_in <= 1'b1;
        @(posedge core_clk_in);
        selftest_start_in <= 1'b0;
        rd(`PSTP_ADDR_CTRL, 16'h0020, "errcnt restart");
        // gap length after each finished sequence, short then long
        for (int g = 0; g < 2; g++) begin
            wr(`PSTP_ADDR_CTRL, 16'h0000);
            wr(`PSTP_ADDR_CTRL, g ? 16'h0014 : 16'h0010);
            wait_for(1'b1, 100);
            wait_for(1'b0, 2000);
            chk("gap", 16'h0001, {15'h0000, n >= (g ? 1500 : 1000) && n <= (g ? 1502 : 1002)});
        end
        wr(`PSTP_ADDR_CTRL, 16'h0000);
        n = 0;
        repeat (1600) begin
            @(posedge core_clk_in);
            #1 n += (seq_start_out === 1'b1);
        end
        chk("starts off", 16'h0000, n[15:0]);
        end_of_test();
    end
endmodule
